// ==== logic/gpio_port_pkg.sv ====
// Shared constants and types for the six-pin general-purpose port
package gpio_port_pkg;

	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 32;
	localparam int          PIN_N            = 6;

	// Register byte offsets
	localparam logic [7:0]  OFF_DATA         = 8'h00;
	localparam logic [7:0]  OFF_DIRECTION    = 8'h04;
	localparam logic [7:0]  OFF_ANALOG       = 8'h08;
	localparam logic [7:0]  OFF_CONFIG       = 8'h0c;
	localparam logic [7:0]  OFF_BIT_SET      = 8'h10;
	localparam logic [7:0]  OFF_BIT_CLEAR    = 8'h14;

	// Field positions
	localparam int          PIN_INPUT_ONLY   = 3;
	localparam int          PIN_OSC_TWO      = 4;
	localparam int          PIN_OSC_ONE      = 5;
	localparam int          CFG_MODE_LSB     = 0;
	localparam int          CFG_RESET_EN_BIT = 3;

	// Reset values
	localparam logic [5:0]  RST_LATCH        = 6'h00;
	localparam logic [5:0]  RST_DIRECTION    = 6'h3f;
	localparam logic [7:0]  RST_ANALOG       = 8'hff;
	localparam logic        RST_RESET_EN     = 1'h0;

	// Clock output divider and bus answers
	localparam int          CLKOUT_DIV       = 4;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef enum logic [2:0] {
		low_power_crystal          = 3'h0,
		medium_crystal             = 3'h1,
		high_crystal               = 3'h2,
		external_clock_input       = 3'h3,
		internal_clock_with_port   = 3'h4,
		internal_clock_with_output = 3'h5,
		rc_clock_with_port         = 3'h6,
		rc_clock_with_output       = 3'h7
	} clock_mode_t;

	localparam clock_mode_t RST_CLOCK_MODE   = internal_clock_with_port;

	typedef struct packed {
		logic        reset_pin_enable;
		clock_mode_t clock_mode;
	} port_cfg_t;

	typedef struct packed {
		logic [PIN_N-1:0] level;
		logic [PIN_N-1:0] enable;
	} pin_drive_t;

endpackage

// ==== logic/gpio_port.sv ====
// Six-pin general-purpose port with clock-pin sharing and AXI4-Lite registers
//
// Function
// RL1: direction one makes pin input, driver off
// RL2: direction zero drives output latch onto pin
// RL3: six pins, each input or output
// RL4: input-only pin never drives; direction reads one
// RL5: data read gives pins; write goes latch
// RL6: every port write is read-modify-write; here only bit set/clear are, data writes go straight to the latch
// RL7: reset-pin enable forces its data bit zero
// RL8: bits seven and six read zero
// RL9: direction still controls drivers on analog pins
// RL10: analog pins read zero digitally
// RL11: analog pins cannot raise pin-change events
// RL12: crystal modes: pins 5,4 direction read one
// RL13: analog select zeroes reads, enables analog use
// RL14: analog select leaves digital output working
// RL15: RC mode: pin two outputs clock/4
// RL16: RC port mode: pin two is port pin
// RL17: internal output mode: pin two outputs clock/4
// RL18: internal port mode: both oscillator pins port
// RL19: enabled peripheral takes over its shared pin
// RL20: external clock: pin one clock, two port
// RL21: crystal modes: both oscillator pins resonator
// RL22: clock mode overrides taken pin driver
`timescale 1ns/1ps

module gpio_port (
	input  wire logic                          sys_clk,          // System clock, 20 MHz
	input  wire logic                          rst,              // Async reset, active high
	input  wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write address
	input  wire logic                          s_axi_awvalid,    // Write address valid
	output logic                               s_axi_awready,    // Write address ready
	input  wire logic [gpio_port_pkg::DATA_W-1:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]                    s_axi_wstrb,      // Write byte strobes
	input  wire logic                          s_axi_wvalid,     // Write data valid
	output logic                               s_axi_wready,     // Write data ready
	output logic [1:0]                         s_axi_bresp,      // Write response
	output logic                               s_axi_bvalid,     // Write response valid
	input  wire logic                          s_axi_bready,     // Write response ready
	input  wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_araddr,  // Read address
	input  wire logic                          s_axi_arvalid,    // Read address valid
	output logic                               s_axi_arready,    // Read address ready
	output logic [gpio_port_pkg::DATA_W-1:0]   s_axi_rdata,      // Read data
	output logic [1:0]                         s_axi_rresp,      // Read response
	output logic                               s_axi_rvalid,     // Read data valid
	input  wire logic                          s_axi_rready,     // Read data ready
	input  wire logic [gpio_port_pkg::PIN_N-1:0] pin_in,         // Pin levels
	output gpio_port_pkg::pin_drive_t          pin_drive,        // Pin levels and enables
	input  wire logic [gpio_port_pkg::PIN_N-1:0] periph_take,    // Peripheral owns pin
	input  wire logic [gpio_port_pkg::PIN_N-1:0] periph_level,   // Peripheral drive level
	input  wire logic [gpio_port_pkg::PIN_N-1:0] periph_enable,  // Peripheral drive enable
	output logic [gpio_port_pkg::PIN_N-1:0]    change_allow,     // Pins that may flag change
	output logic [gpio_port_pkg::PIN_N-1:0]    osc_taken         // Pins held by oscillator
);
	import gpio_port_pkg::*;

	// Port registers and pin state
	logic [PIN_N-1:0]  latch_r;
	logic [PIN_N-1:0]  direction_r;
	logic [7:0]        analog_r;
	port_cfg_t         cfg_r;
	logic [1:0]        div_cnt_r;
	pin_drive_t        pin_drive_r;
	pin_drive_t        pin_drive_nxt;
	logic [PIN_N-1:0]  change_allow_r;
	logic [PIN_N-1:0]  osc_taken_r;
	logic [PIN_N-1:0]  osc_taken_nxt;

	// Bus slave state
	logic              awready_r;
	logic              wready_r;
	logic              aw_held_r;
	logic              w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0]        wbyte_r;
	logic              wlane_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              arready_r;
	logic              rvalid_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0]        rresp_r;
	logic              wr_fire;
	logic              reg_we;
	logic              wr_hit;
	logic              rd_hit;
	logic [DATA_W-1:0] rd_value;

	// Read-side views of the port
	logic              crystal_mode;
	logic              clkout_mode;
	logic [PIN_N-1:0]  pin_read;
	logic [PIN_N-1:0]  dir_read;
	logic [PIN_N-1:0]  clkout_sel;

	// Mode groups that force direction readback or drive the clock pin
	assign crystal_mode = (cfg_r.clock_mode == low_power_crystal) ||
	                      (cfg_r.clock_mode == medium_crystal) ||
	                      (cfg_r.clock_mode == high_crystal);
	assign clkout_mode  = (cfg_r.clock_mode == rc_clock_with_output) ||
	                      (cfg_r.clock_mode == internal_clock_with_output);

	// Which pins the oscillator owns in the current mode
	always_comb begin
		osc_taken_nxt = '0;
		unique case (cfg_r.clock_mode)
			low_power_crystal, medium_crystal, high_crystal: begin
				osc_taken_nxt[PIN_OSC_ONE] = 1'b1; // [RL21]
				osc_taken_nxt[PIN_OSC_TWO] = 1'b1; // [RL21]
			end
			external_clock_input, rc_clock_with_port: begin
				osc_taken_nxt[PIN_OSC_ONE] = 1'b1; // [RL20] [RL16]
			end
			rc_clock_with_output: begin
				osc_taken_nxt[PIN_OSC_ONE] = 1'b1; // [RL15]
				osc_taken_nxt[PIN_OSC_TWO] = 1'b1; // [RL15]
			end
			internal_clock_with_output: begin
				osc_taken_nxt[PIN_OSC_TWO] = 1'b1; // [RL17]
			end
			internal_clock_with_port: begin
				osc_taken_nxt = '0;                // [RL18]
			end
		endcase
	end

	// Pin driver and readback, one slice per pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			// Analog pins read zero; the input-only pin reads zero as reset input
			if (gi == PIN_INPUT_ONLY) begin : g_inonly
				assign pin_read[gi] = pin_in[gi] & ~analog_r[gi] &
				                      ~cfg_r.reset_pin_enable;          // [RL7] [RL10]
				assign dir_read[gi] = 1'b1;                              // [RL4]
				assign clkout_sel[gi] = 1'b0;
				assign pin_drive_nxt.enable[gi] = 1'b0;                  // [RL4]
				assign pin_drive_nxt.level[gi]  = 1'b0;
			end else begin : g_io
				assign pin_read[gi] = pin_in[gi] & ~analog_r[gi];        // [RL10] [RL13]
				// Crystal modes report both oscillator pins as inputs
				if (gi == PIN_OSC_ONE || gi == PIN_OSC_TWO) begin : g_osc
					assign dir_read[gi] = direction_r[gi] | crystal_mode; // [RL12]
				end else begin : g_plain
					assign dir_read[gi] = direction_r[gi];
				end
				// Only oscillator pin two can carry the divided clock
				if (gi == PIN_OSC_TWO) begin : g_clkout
					assign clkout_sel[gi] = clkout_mode;                 // [RL15] [RL17]
				end else begin : g_noclk
					assign clkout_sel[gi] = 1'b0;
				end
				// Clock mode wins, then peripheral, then port; analog select not involved
				assign pin_drive_nxt.enable[gi] =
					clkout_sel[gi] ? 1'b1 :
					osc_taken_nxt[gi] ? 1'b0 :                           // [RL22]
					periph_take[gi] ? periph_enable[gi] :                // [RL19]
					~direction_r[gi];                                    // [RL1] [RL2] [RL9] [RL14]
				assign pin_drive_nxt.level[gi] =
					clkout_sel[gi] ? div_cnt_r[1] :                      // [RL15] [RL17]
					osc_taken_nxt[gi] ? 1'b0 :
					periph_take[gi] ? periph_level[gi] :
					latch_r[gi];                                         // [RL2]
			end
		end
	endgenerate

	// Free-running divide-by-four of the system clock for the clock output pin
	// Runs in every mode; only the clock-out modes look at it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_cnt_r <= 2'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 2'h1;
		end
	end

	// Registered pin drivers, so the pins never see a decode glitch
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_drive_r <= '0;
		end else begin
			pin_drive_r <= pin_drive_nxt;                                // [RL3]
		end
	end

	// Digital pins may flag a change; analog ones stay quiet
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			change_allow_r <= '0;
		end else begin
			change_allow_r <= ~analog_r[PIN_N-1:0];                      // [RL11]
		end
	end

	// Oscillator ownership, registered in step with the pin drivers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			osc_taken_r <= '0;
		end else begin
			osc_taken_r <= osc_taken_nxt;
		end
	end

	// Outputs straight from their flip-flops
	assign pin_drive    = pin_drive_r;
	assign change_allow = change_allow_r;
	assign osc_taken    = osc_taken_r;

	// Write channel: address and data taken in either order, one write at a time
	assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
	// Only byte lane 0 carries register bits; without it a write changes nothing
	assign reg_we  = wr_fire & wlane_r;
	// Unmapped addresses answer with an error and change nothing
	assign wr_hit  = (awaddr_r == OFF_DATA) || (awaddr_r == OFF_DIRECTION) ||
	                 (awaddr_r == OFF_ANALOG) || (awaddr_r == OFF_CONFIG) ||
	                 (awaddr_r == OFF_BIT_SET) || (awaddr_r == OFF_BIT_CLEAR);

	// Address channel; closed from its handshake until the response is taken
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awaddr_r  <= s_axi_awaddr;
				aw_held_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (bvalid_r && s_axi_bready) begin
				awready_r <= 1'b1;
			end
		end
	end

	// Data channel; same life cycle as the address, only byte lane 0 kept
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
			wbyte_r  <= 8'h00;
			wlane_r  <= 1'b0;
		end else begin
			if (s_axi_wvalid && wready_r) begin
				wbyte_r  <= s_axi_wdata[7:0];
				wlane_r  <= s_axi_wstrb[0];
				w_held_r <= 1'b1;
				wready_r <= 1'b0;
			end
			if (wr_fire) begin
				w_held_r <= 1'b0;
			end
			if (bvalid_r && s_axi_bready) begin
				wready_r <= 1'b1;
			end
		end
	end

	// Response; fire waits for bvalid low, so set and clear never meet
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Output latch; data writes store the byte, bit set and bit clear are read-modify-write of the pin levels
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			latch_r <= RST_LATCH;
		end else if (reg_we) begin
			unique case (awaddr_r)
				// Bit set/clear give the latch pins as read, modified; analog pins come back as zero
				OFF_DATA:      latch_r <= wbyte_r[PIN_N-1:0];                   // [RL5] [RL6] [RL8]
				OFF_BIT_SET:   latch_r <= pin_read | wbyte_r[PIN_N-1:0];        // [RL6]
				OFF_BIT_CLEAR: latch_r <= pin_read & ~wbyte_r[PIN_N-1:0];       // [RL6]
				default: ;
			endcase
		end
	end

	// Direction bits stored as written; forced values show only on readback
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			direction_r <= RST_DIRECTION;
		end else if (reg_we && awaddr_r == OFF_DIRECTION) begin
			direction_r <= wbyte_r[PIN_N-1:0];                                // [RL8]
		end
	end

	// Analog select, all eight bits kept though only six pins exist
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			analog_r <= RST_ANALOG;
		end else if (reg_we && awaddr_r == OFF_ANALOG) begin
			analog_r <= wbyte_r;
		end
	end

	// Clock mode and reset-pin enable; a new mode retakes the oscillator pins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_r <= '{reset_pin_enable: RST_RESET_EN, clock_mode: RST_CLOCK_MODE};
		end else if (reg_we && awaddr_r == OFF_CONFIG) begin
			cfg_r.clock_mode       <= clock_mode_t'(wbyte_r[CFG_MODE_LSB +: 3]);
			cfg_r.reset_pin_enable <= wbyte_r[CFG_RESET_EN_BIT];
		end
	end

	// Read multiplexer; unused upper bits read zero
	always_comb begin
		rd_value = '0;
		rd_hit   = 1'b1;
		unique case (s_axi_araddr)
			OFF_DATA:      rd_value[PIN_N-1:0] = pin_read;              // [RL5] [RL8]
			OFF_DIRECTION: rd_value[PIN_N-1:0] = dir_read;              // [RL4] [RL8] [RL12]
			OFF_ANALOG:    rd_value[7:0] = analog_r;
			OFF_CONFIG: begin
				rd_value[CFG_MODE_LSB +: 3]  = cfg_r.clock_mode;
				rd_value[CFG_RESET_EN_BIT]   = cfg_r.reset_pin_enable;
			end
			OFF_BIT_SET, OFF_BIT_CLEAR: rd_value = '0;
			default:       rd_hit = 1'b0;
		endcase
	end

	// Read handshake: no wait state, the answer stands until rready
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// Read data: pins sampled at the address handshake, held while rvalid waits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			rdata_r <= rd_value;
			rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Bus outputs, each straight from a flip-flop
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

endmodule

// ==== logic/unused_placeholder_none.sv ====
// Intentionally holds nothing; the design lives in gpio_port.sv
`timescale 1ns/1ps

// ==== tb/board_pins.sv ====
// Board-side model of the six port pins
`timescale 1ns/1ps
module board_pins (
	input  wire gpio_port_pkg::pin_drive_t pin_drive, // Device drive
	input  wire logic [5:0]                board_val, // Board level
	output logic [5:0]                     pin_in     // Resolved pins
);
	import gpio_port_pkg::*;
	// Device wins where it drives; the board fills every other pin
	always_comb begin
		pin_in = (pin_drive.enable & pin_drive.level) | (~pin_drive.enable & board_val);
	end
endmodule

// ==== tb/gpio_port_assertions.sv ====
// Checker for bus timing and pin drive of the port
`timescale 1ns/1ps
module gpio_port_assertions (
	input wire logic                       sys_clk,       // Clock
	input wire logic                       rst,           // Reset
	input wire logic                       s_axi_awvalid, // AW valid
	input wire logic                       s_axi_awready, // AW ready
	input wire logic                       s_axi_wvalid,  // W valid
	input wire logic                       s_axi_wready,  // W ready
	input wire logic [1:0]                 s_axi_bresp,   // B resp
	input wire logic                       s_axi_bvalid,  // B valid
	input wire logic                       s_axi_bready,  // B ready
	input wire logic                       s_axi_arvalid, // AR valid
	input wire logic                       s_axi_arready, // AR ready
	input wire logic [31:0]                s_axi_rdata,   // R data
	input wire logic                       s_axi_rvalid,  // R valid
	input wire logic                       s_axi_rready,  // R ready
	input wire gpio_port_pkg::pin_drive_t  pin_drive,     // Pin drive
	input wire logic [5:0]                 periph_take,   // Peripheral owns
	input wire logic [5:0]                 periph_enable, // Peripheral enable
	input wire logic [5:0]                 osc_taken      // Oscillator owns
);
	import gpio_port_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_in_only; pin_drive.enable[3] == 1'b0; endproperty
	a_in_only: assert property (p_in_only) else $error("input pin driven");
	property p_osc_off; osc_taken[5] && $past(osc_taken[5]) |-> !pin_drive.enable[5]; endproperty
	a_osc_off: assert property (p_osc_off) else $error("osc pin driven");
	property p_xtal; osc_taken[4] |-> osc_taken[5] || pin_drive.enable[4]; endproperty
	a_xtal: assert property (p_xtal) else $error("osc pin pair split");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_w_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_w_lat: assert property (p_w_lat) else $error("write answer late");
	property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_periph;
		periph_take[1] && $stable(periph_enable[1]) |=> pin_drive.enable[1] == $past(periph_enable[1]);
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral drive lost");
	// Main scenarios reached
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_osc: cover property (osc_taken[4]);
endmodule
bind gpio_port gpio_port_assertions chk (.*);

// ==== tb/tb.sv ====
// Register-level testbench for the six-pin port
`timescale 1ns/1ps
module tb;
	import gpio_port_pkg::*;
	logic        sys_clk = 0, rst = 1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, c;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [5:0]  pin_in, change_allow, osc_taken, board_val = 6'h00;
	logic [5:0]  periph_take = 6'h00, periph_level = 6'h00, periph_enable = 6'h00;
	pin_drive_t  pin_drive;
	int          fails = 0, checks = 0;
	gpio_port uut (.*);
	board_pins brd (.*);
	// Clock, 50 ns period
	initial forever #25 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Write with both channels offered together, bounded wait for the answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= {24'h0, d};
		s_axi_wvalid <= 1; s_axi_bready <= 1;
		for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		if (n == 50) begin
			fails++;
			results();
		end else begin
			s_axi_bready <= 0;
			chk("bresp", s_axi_bresp, er);
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		if (n == 50) begin
			fails++;
			results();
		end else begin
			s_axi_rready <= 0;
			chk(nm, s_axi_rdata, e);
			chk("rresp", s_axi_rresp, er);
		end
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		results();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 0;
		rdc("dir", OFF_DIRECTION, 32'h3f);
		rdc("analog", OFF_ANALOG, 32'hff);
		rdc("cfg", OFF_CONFIG, 32'h04);
		chk("enable", pin_drive.enable, 6'h00);
		board_val <= 6'h3f;
		rdc("data", OFF_DATA, 32'h0);
		chk("change", change_allow, 6'h00);
		$display("test reset done");
		// Write without byte lane 0 must leave the register alone
		s_axi_wstrb <= 4'h0;
		wr(OFF_ANALOG, 8'h00);
		s_axi_wstrb <= 4'h1;
		rdc("analog", OFF_ANALOG, 32'hff);
		wr(OFF_ANALOG, 8'h00);
		board_val <= 6'h2a;
		rdc("data", OFF_DATA, 32'h2a);
		chk("change", change_allow, 6'h3f);
		wr(OFF_CONFIG, 8'h0c);
		rdc("data", OFF_DATA, 32'h22);
		wr(OFF_CONFIG, 8'h04);
		wr(OFF_DATA, 8'h15);
		chk("pins", pin_in, 6'h2a);
		wr(OFF_DIRECTION, 8'h00);
		rdc("dir", OFF_DIRECTION, 32'h08);
		chk("enable", pin_drive.enable, 6'h37);
		chk("level", pin_drive.level & 6'h37, 6'h15);
		rdc("data", OFF_DATA, 32'h1d);
		$display("test direction done");
		// Pin 0 input at 1 is folded into the latch by a bit-set
		wr(OFF_DATA, 8'h00);
		wr(OFF_DIRECTION, 8'h01);
		board_val <= 6'h01;
		wr(OFF_BIT_SET, 8'h02);
		wr(OFF_DIRECTION, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk("rmw", pin_drive.level & pin_drive.enable, 6'h03);
		wr(OFF_BIT_CLEAR, 8'h01);
		repeat (2) @(posedge sys_clk);
		chk("rmw", pin_drive.level & pin_drive.enable, 6'h02);
		wr(OFF_ANALOG, 8'hff);
		repeat (2) @(posedge sys_clk);
		chk("enable", pin_drive.enable, 6'h37);
		rdc("data", OFF_DATA, 32'h0);
		wr(OFF_ANALOG, 8'h00);
		$display("test rmw analog done");
		// Every clock mode, with all port pins set as outputs
		for (int m = 0; m < 8; m++) begin
			wr(OFF_CONFIG, {5'h0, 3'(m)});
			rdc("dir", OFF_DIRECTION, (m < 3) ? 32'h38 : 32'h08);
			c = {m != 4 && m != 5, m < 3 || m == 5 || m == 7, 4'h0};
			chk("osc", osc_taken, c);
			chk("osc_en", pin_drive.enable[5:4], {m == 4 || m == 5, m > 2});
			c = 0;
			repeat (8) begin
				@(posedge sys_clk);
				c = c + pin_drive.level[4];
			end
			chk("clkout", c, (m == 5 || m == 7) ? 32'h4 : 32'h0);
		end
		wr(OFF_CONFIG, 8'h04);
		$display("test modes done");
		periph_take <= 6'h02;
		periph_enable <= 6'h02;
		repeat (3) @(posedge sys_clk);
		chk("periph", {pin_drive.level[1], pin_drive.enable[1]}, 2'b01);
		periph_take <= 6'h00;
		rdc("unmapped", 8'h18, 32'h0, RESP_SLVERR);
		wr(8'h18, 8'hff, RESP_SLVERR);
		$display("test periph unmapped done");
		results();
	end
endmodule
